//--- hw/hpp_pkg.sv
package hpp_pkg;
    // number of downstream ports
    localparam int NUM_PORTS = 4;
    // core clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 40;
    // overcurrent filter: stable low time in nanoseconds
    localparam int OC_FILTER_NS = 320;
    // filter length in cycles, rounded up, at least one
    localparam int OC_FILTER_CYC = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // width of the filter counter
    localparam int OC_CNT_W = 4;
    // serial memory clock divider half period in core cycles
    localparam int MEM_CLK_HALF_CYC = 8;
    // width of the memory clock divider counter
    localparam int MEM_DIV_W = 4;
    // reset level of the power enables: off (high)
    localparam logic [3:0] PWR_EN_N_RST = 4'hF;
    // reset level of the suspend status output
    localparam logic SUSPEND_RST = 1'b0;
    // mode of the power switching
    typedef enum logic {HPP_PER_PORT, HPP_GANGED} hpp_mode_e;
endpackage : hpp_pkg

//--- hw/hpp_oc_if.sv
`timescale 1ns/1ps
// carries synchronised overcurrent levels to the filter and filtered flags back
interface hpp_oc_if;
    import hpp_pkg::*;
    logic [NUM_PORTS-1:0] oc_sync_n; // synchronised active-low inputs
    logic [NUM_PORTS-1:0] oc_flag; // filtered overcurrent, active high
    modport top (output oc_sync_n, input oc_flag);
    modport filt (input oc_sync_n, output oc_flag);
endinterface : hpp_oc_if

//--- hw/hpp_oc_filter.sv
`timescale 1ns/1ps
// per-port noise filter on the active-low overcurrent inputs
module hpp_oc_filter
    import hpp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    hpp_oc_if.filt oc
);
    ////////////////////////////////////////////////////////////////////////////////
    // per-port counters of consecutive low samples
    logic [OC_CNT_W-1:0] cnt_q [NUM_PORTS];
    logic [OC_CNT_W-1:0] cnt_d [NUM_PORTS];
    logic [NUM_PORTS-1:0] flag_q;
    logic [NUM_PORTS-1:0] flag_d;

    // count stable low, clear on any high sample so spikes are dropped
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            cnt_d[i] = cnt_q[i];
            flag_d[i] = flag_q[i];
            if (oc.oc_sync_n[i]) begin // line high: no overcurrent
                cnt_d[i] = '0;
                flag_d[i] = 1'b0;
            end else if (cnt_q[i] < OC_CNT_W'(OC_FILTER_CYC)) begin
                cnt_d[i] = cnt_q[i] + OC_CNT_W'(1); // [RULE8] [RULE20]
            end else begin
                flag_d[i] = 1'b1; // [RULE20]
            end
        end
    end

    // register the filter state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin // [RULE10]
            for (int i = 0; i < NUM_PORTS; i++) begin
                cnt_q[i] <= '0;
            end
            flag_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign oc.oc_flag = flag_q;
endmodule : hpp_oc_filter

//--- hw/hpp_top.sv
// Summary of operation
// RULE1 - memory enable high disables memory interface
// RULE2 - enable low: tri-state memory clock output (code drives it when enable is low, tri-states it when high)
// RULE3 - enable high: data pin is ganged strap
// RULE4 - enable low: data pin is bidirectional data
// RULE5 - board keeps ganged strap static
// RULE6 - per-port: one overcurrent input per port
// RULE7 - ganged: board ties overcurrent inputs together
// RULE8 - overcurrent inputs are noise filtered
// RULE9 - power enables push-pull, low means on
// RULE10 - reset initialises all logic
// RULE11 - system asserts reset at power-up
// RULE12 - clock runs during last reset part
// RULE13 - suspend output high in suspend
// RULE14 - board straps clock source select
// RULE15 - direct clock pin low for crystal
// RULE16 - crystal mode uses clock multiplier
// RULE17 - select high bypasses and powers down multiplier
// RULE18 - ganged: all ports off on overcurrent
// RULE19 - per-port: overcurrent turns off own port
// RULE20 - filter needs fixed stable-low cycle count
`timescale 1ns/1ps
module hpp_top
    import hpp_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic SERIAL_MEM_ENABLE_N_IN,
    input wire logic CLOCK_SOURCE_SELECT_IN,
    input wire logic [NUM_PORTS-1:0] PORT_OVERCURRENT_N_IN,
    input wire logic [NUM_PORTS-1:0] PORT_POWER_REQ_IN,
    input wire logic HUB_SUSPEND_IN,
    input wire logic MEM_XFER_EN_IN,
    input wire logic MEM_DATA_DRIVE_IN,
    input wire logic MEM_DATA_OE_IN,
    input wire logic MEM_DATA_OR_POWER_MODE_IN,
    output logic MEM_DATA_OR_POWER_MODE_OUT,
    output logic MEM_DATA_OR_POWER_MODE_OE_OUT,
    output logic MEM_SERIAL_CLK_OUT,
    output logic MEM_SERIAL_CLK_OE_OUT,
    output logic MEM_DATA_RX_OUT,
    output logic [NUM_PORTS-1:0] PORT_POWER_ENABLE_N_OUT,
    output logic [NUM_PORTS-1:0] PORT_OVERCURRENT_OUT,
    output logic SUSPEND_STATUS_OUT,
    output logic GANGED_MODE_OUT,
    output logic USE_DIRECT_CLOCK_OUT,
    output logic MULT_POWER_DOWN_OUT
);
    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers: two flops per pin
    logic [NUM_PORTS-1:0] oc_s1_q, oc_s2_q; // overcurrent lines
    logic [2:0] pin_s1_q, pin_s2_q; // mem enable, clock select, data/mode pin
    logic sync_ok;

    hpp_oc_if oc_bus();

    // first stage feeds only the second stage
    always_ff @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin // [RULE10]
            oc_s1_q <= '1;
            oc_s2_q <= '1;
            pin_s1_q <= 3'h1;
            pin_s2_q <= 3'h1;
        end else begin
            oc_s1_q <= PORT_OVERCURRENT_N_IN;
            oc_s2_q <= oc_s1_q;
            pin_s1_q <= {MEM_DATA_OR_POWER_MODE_IN, CLOCK_SOURCE_SELECT_IN,
                         SERIAL_MEM_ENABLE_N_IN};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign oc_bus.oc_sync_n = oc_s2_q; // [RULE6]

    // noise filter on each overcurrent line
    hpp_oc_filter u_filter (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RSTN_IN),
        .oc(oc_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // strap capture: straps are latched once after reset release
    logic mem_en_n_q, mem_en_n_d; // serial memory disabled when high
    logic clk_sel_q, clk_sel_d; // direct fast clock selected when high
    hpp_mode_e mode_q, mode_d; // ganged or per-port
    logic captured_q, captured_d; // straps taken
    logic [1:0] settle_q, settle_d; // waits for synchronisers to fill

    assign sync_ok = (settle_q == 2'h3);

    // take straps once synchronisers hold real pin levels
    always_comb begin
        mem_en_n_d = mem_en_n_q;
        clk_sel_d = clk_sel_q;
        mode_d = mode_q;
        captured_d = captured_q;
        settle_d = settle_q;
        if (!sync_ok) begin
            settle_d = settle_q + 2'h1;
        end else if (!captured_q) begin // board holds straps static [RULE5]
            captured_d = 1'b1;
            mem_en_n_d = pin_s2_q[0];
            clk_sel_d = pin_s2_q[1]; // [RULE14]
            if (pin_s2_q[0]) begin // shared pin is the mode strap [RULE3]
                mode_d = pin_s2_q[2] ? HPP_GANGED : HPP_PER_PORT;
            end else begin // shared pin carries memory data, per-port [RULE4]
                mode_d = HPP_PER_PORT;
            end
        end
    end

    // register strap state
    always_ff @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin // [RULE10]
            mem_en_n_q <= 1'b1;
            clk_sel_q <= 1'b0;
            mode_q <= HPP_PER_PORT;
            captured_q <= 1'b0;
            settle_q <= 2'h0;
        end else begin
            mem_en_n_q <= mem_en_n_d;
            clk_sel_q <= clk_sel_d;
            mode_q <= mode_d;
            captured_q <= captured_d;
            settle_q <= settle_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power enables, overcurrent status, suspend and clock select outputs
    logic [NUM_PORTS-1:0] pwr_n_q, pwr_n_d;
    logic [NUM_PORTS-1:0] oc_out_q, oc_out_d;
    logic susp_q, susp_d;
    logic gang_q, gang_d;
    logic dclk_q, dclk_d;
    logic pdn_q, pdn_d;

    // gate power requests with filtered overcurrent
    always_comb begin
        oc_out_d = oc_bus.oc_flag;
        pwr_n_d = ~PORT_POWER_REQ_IN; // low means on [RULE9]
        if (!captured_q) begin // hold off until straps known
            pwr_n_d = PWR_EN_N_RST;
            oc_out_d = '0;
        end else if (mode_q == HPP_GANGED) begin
            // one shared line; any input serves [RULE7]
            oc_out_d = {NUM_PORTS{|oc_bus.oc_flag}};
            pwr_n_d = {NUM_PORTS{~PORT_POWER_REQ_IN[0] | (|oc_bus.oc_flag)}}; // [RULE18]
        end else begin
            pwr_n_d = ~PORT_POWER_REQ_IN | oc_bus.oc_flag; // [RULE19] [RULE6]
        end
        susp_d = HUB_SUSPEND_IN; // [RULE13]
        gang_d = (mode_q == HPP_GANGED);
        dclk_d = clk_sel_q; // core from direct input when high [RULE17]
        pdn_d = clk_sel_q; // multiplier and oscillator off [RULE17] [RULE16]
    end

    // register output state
    always_ff @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin // [RULE10]
            pwr_n_q <= PWR_EN_N_RST;
            oc_out_q <= '0;
            susp_q <= SUSPEND_RST;
            gang_q <= 1'b0;
            dclk_q <= 1'b0;
            pdn_q <= 1'b0;
        end else begin
            pwr_n_q <= pwr_n_d;
            oc_out_q <= oc_out_d;
            susp_q <= susp_d;
            gang_q <= gang_d;
            dclk_q <= dclk_d;
            pdn_q <= pdn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial memory pins: clock divider and tri-state control
    logic [MEM_DIV_W-1:0] div_q, div_d;
    logic mclk_q, mclk_d;
    logic mclk_oe_q, mclk_oe_d;
    logic mdat_q, mdat_d;
    logic mdat_oe_q, mdat_oe_d;
    logic mrx_q, mrx_d;
    logic mem_on;

    assign mem_on = captured_q && !mem_en_n_q;

    // divide core clock for the memory, release pins when disabled
    always_comb begin
        div_d = div_q;
        mclk_d = 1'b0;
        mclk_oe_d = 1'b0; // pin undriven [RULE1]
        mdat_d = 1'b0;
        mdat_oe_d = 1'b0; // shared pin is input only [RULE3]
        mrx_d = 1'b0;
        if (mem_on) begin
            mclk_oe_d = 1'b1; // [RULE2]
            mclk_d = mclk_q;
            if (MEM_XFER_EN_IN) begin
                if (div_q == MEM_DIV_W'(MEM_CLK_HALF_CYC - 1)) begin
                    div_d = '0;
                    mclk_d = ~mclk_q; // [RULE2]
                end else begin
                    div_d = div_q + MEM_DIV_W'(1);
                end
            end else begin
                div_d = '0;
                mclk_d = 1'b0;
            end
            mdat_oe_d = MEM_DATA_OE_IN; // [RULE4]
            mdat_d = MEM_DATA_DRIVE_IN;
            mrx_d = pin_s2_q[2]; // [RULE4]
        end else begin
            div_d = '0;
        end
    end

    // register memory pin state
    always_ff @(posedge REF_CLK_IN) begin
        if (!RSTN_IN) begin // [RULE10]
            div_q <= '0;
            mclk_q <= 1'b0;
            mclk_oe_q <= 1'b0;
            mdat_q <= 1'b0;
            mdat_oe_q <= 1'b0;
            mrx_q <= 1'b0;
        end else begin
            div_q <= div_d;
            mclk_q <= mclk_d;
            mclk_oe_q <= mclk_oe_d;
            mdat_q <= mdat_d;
            mdat_oe_q <= mdat_oe_d;
            mrx_q <= mrx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output assignments, all from flops
    assign PORT_POWER_ENABLE_N_OUT = pwr_n_q;
    assign PORT_OVERCURRENT_OUT = oc_out_q;
    assign SUSPEND_STATUS_OUT = susp_q;
    assign GANGED_MODE_OUT = gang_q;
    assign USE_DIRECT_CLOCK_OUT = dclk_q;
    assign MULT_POWER_DOWN_OUT = pdn_q;
    assign MEM_SERIAL_CLK_OUT = mclk_q;
    assign MEM_SERIAL_CLK_OE_OUT = mclk_oe_q;
    assign MEM_DATA_OR_POWER_MODE_OUT = mdat_q;
    assign MEM_DATA_OR_POWER_MODE_OE_OUT = mdat_oe_q;
    assign MEM_DATA_RX_OUT = mrx_q;
endmodule : hpp_top

//--- test/hpp_board_model.sv
`timescale 1ns/1ps
// board side: power switches, shared pin strap and serial memory driver
module hpp_board_model
    import hpp_pkg::*;
(
    input wire logic ganged_in,
    input wire logic [NUM_PORTS-1:0] fault_in,
    input wire logic strap_in,
    input wire logic mem_oe_in,
    input wire logic mem_bit_in,
    input wire logic dut_oe_in,
    input wire logic dut_bit_in,
    output logic [NUM_PORTS-1:0] oc_n_out,
    output logic pin_out
);
    // ganged boards wire all fault lines into one common line
    assign oc_n_out = ganged_in ? {NUM_PORTS{~|fault_in}} : ~fault_in;
    // device drive wins, then memory, else static strap or pulldown level
    assign pin_out = dut_oe_in ? dut_bit_in : (mem_oe_in ? mem_bit_in : strap_in);
endmodule : hpp_board_model

//--- test/hpp_top_checker.sv
`timescale 1ns/1ps
// port-level relations of the strap and power control block
module hpp_top_checker
    import hpp_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [NUM_PORTS-1:0] PORT_OVERCURRENT_N_IN,
    input wire logic HUB_SUSPEND_IN,
    input wire logic MEM_DATA_OE_IN,
    input wire logic MEM_DATA_OR_POWER_MODE_OE_OUT,
    input wire logic MEM_SERIAL_CLK_OUT,
    input wire logic MEM_SERIAL_CLK_OE_OUT,
    input wire logic MEM_DATA_RX_OUT,
    input wire logic [NUM_PORTS-1:0] PORT_POWER_ENABLE_N_OUT,
    input wire logic [NUM_PORTS-1:0] PORT_OVERCURRENT_OUT,
    input wire logic SUSPEND_STATUS_OUT,
    input wire logic GANGED_MODE_OUT,
    input wire logic USE_DIRECT_CLOCK_OUT,
    input wire logic MULT_POWER_DOWN_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    chk_strap_mem_off: assert property (GANGED_MODE_OUT |-> !MEM_SERIAL_CLK_OE_OUT
        && !MEM_DATA_OR_POWER_MODE_OE_OUT) else $error("memory pins on in ganged mode");
    chk_rx_quiet: assert property (!MEM_SERIAL_CLK_OE_OUT |-> !MEM_DATA_RX_OUT)
        else $error("data rx active with memory off");
    chk_pll_bypass: assert property (MULT_POWER_DOWN_OUT == USE_DIRECT_CLOCK_OUT)
        else $error("multiplier power down differs from clock select");
    chk_susp_copy: assert property ($past(RSTN_IN, 2) |->
        SUSPEND_STATUS_OUT == $past(HUB_SUSPEND_IN)) else $error("suspend status wrong");
    chk_fault_off: assert property ((PORT_OVERCURRENT_OUT & ~PORT_POWER_ENABLE_N_OUT)
        == 4'h0) else $error("faulted port still powered");
    chk_gang_all: assert property (GANGED_MODE_OUT |->
        PORT_POWER_ENABLE_N_OUT inside {4'h0, 4'hF}) else $error("ganged enables split");
    chk_spike_rej: assert property ($rose(PORT_OVERCURRENT_OUT[1]) && !GANGED_MODE_OUT |->
        !$past(PORT_OVERCURRENT_N_IN[1], 4) && !$past(PORT_OVERCURRENT_N_IN[1], 12))
        else $error("overcurrent flagged without a stable low input");
    chk_clk_half: assert property ($rose(MEM_SERIAL_CLK_OUT) |=> MEM_SERIAL_CLK_OUT[*7])
        else $error("memory clock high phase too short");
    chk_data_oe: assert property ($past(MEM_SERIAL_CLK_OE_OUT) |->
        MEM_DATA_OR_POWER_MODE_OE_OUT == $past(MEM_DATA_OE_IN)) else $error("data oe wrong");
    cov_gang_fault: cover property (GANGED_MODE_OUT && PORT_OVERCURRENT_OUT == 4'hF);
    cov_port_fault: cover property (!GANGED_MODE_OUT && $rose(PORT_OVERCURRENT_OUT[1]));
    cov_mem_clk: cover property ($rose(MEM_SERIAL_CLK_OUT));
endmodule : hpp_top_checker

//--- test/hpp_top_tb.sv
`timescale 1ns/1ps
module hpp_top_tb;
    import hpp_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, mem_en_n = 1'b1, sel = 1'b0, strap = 1'b0, susp = 1'b0;
    logic xfer = 1'b0, drv = 1'b0, oe = 1'b0, mem_oe = 1'b0, mem_bit = 1'b0, pin;
    logic [3:0] fault = 4'h0, req = 4'h0, oc_n, pwr_n, oc;
    logic dat_out, dat_oe, clk_out, clk_oe, rx, susp_o, gang, direct, mpd;
    logic [31:0] notes[$];
    int miscompares = 0, n_checks = 0, seed = 13759, cycles = 0;
    event smp;
    // one snapshot of every output under test except the shared pin data output
    wire [15:0] snap = {pwr_n, oc, susp_o, gang, direct, mpd, clk_oe, dat_oe, clk_out, rx};
    always #20 clk = ~clk; // one oscillator feeds the core, no crystal
    hpp_board_model i_hpp_board_model (.ganged_in(strap & mem_en_n), .fault_in(fault),
        .strap_in(strap), .mem_oe_in(mem_oe), .mem_bit_in(mem_bit), .dut_oe_in(dat_oe),
        .dut_bit_in(dat_out), .oc_n_out(oc_n), .pin_out(pin));
    hpp_top i_hpp_top (.REF_CLK_IN(clk), .RSTN_IN(rstn), .SERIAL_MEM_ENABLE_N_IN(mem_en_n),
        .CLOCK_SOURCE_SELECT_IN(sel), .PORT_OVERCURRENT_N_IN(oc_n), .PORT_POWER_REQ_IN(req),
        .HUB_SUSPEND_IN(susp), .MEM_XFER_EN_IN(xfer), .MEM_DATA_DRIVE_IN(drv),
        .MEM_DATA_OE_IN(oe), .MEM_DATA_OR_POWER_MODE_IN(pin),
        .MEM_DATA_OR_POWER_MODE_OUT(dat_out), .MEM_DATA_OR_POWER_MODE_OE_OUT(dat_oe),
        .MEM_SERIAL_CLK_OUT(clk_out), .MEM_SERIAL_CLK_OE_OUT(clk_oe), .MEM_DATA_RX_OUT(rx),
        .PORT_POWER_ENABLE_N_OUT(pwr_n), .PORT_OVERCURRENT_OUT(oc),
        .SUSPEND_STATUS_OUT(susp_o), .GANGED_MODE_OUT(gang), .USE_DIRECT_CLOCK_OUT(direct),
        .MULT_POWER_DOWN_OUT(mpd));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // note an expected masked snapshot for the watcher
    task automatic expect_out(input logic [15:0] m, input logic [15:0] e);
        notes.push_back({m, e});
        ->smp;
    endtask : expect_out
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("ERROR outputs expected %h seen %h", exp, seen);
            miscompares++;
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // straps are fixed across a reset held with the clock running
    task automatic boot(input logic en_n, input logic s, input logic st);
        mem_en_n <= en_n;
        sel <= s;
        strap <= st;
        rstn <= 1'b0;
        cyc(3);
        expect_out(16'hFFFF, 16'hF000);
        cyc(3);
        rstn <= 1'b1;
        cyc(6);
    endtask : boot
    // watcher takes the oldest note whenever a sample is due
    // outputs launched at the noting edge are looked at once settled, half a cycle later
    always @(smp) begin
        logic [31:0] nt;
        @(negedge clk);
        nt = notes.pop_front();
        chk(snap & nt[31:16], nt[15:0]);
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        cyc(1);
        boot(1'b1, 1'b1, 1'b1);
        expect_out(16'h00FF, 16'h0070);
        req <= 4'h1;
        cyc(2);
        expect_out(16'hFF00, 16'h0000);
        fault <= 4'h4;
        cyc(4);
        fault <= 4'h0;
        cyc(14);
        expect_out(16'hFF00, 16'h0000);
        fault <= 4'h4;
        cyc(13);
        expect_out(16'hFF00, 16'hFF00);
        fault <= 4'h0;
        susp <= 1'b1;
        cyc(1);
        expect_out(16'h0080, 16'h0080);
        susp <= 1'b0;
        cyc(1);
        expect_out(16'h0080, 16'h0000);
        boot(1'b0, 1'b0, 1'b0);
        expect_out(16'h00FF, 16'h0008);
        mem_oe <= 1'b1;
        mem_bit <= 1'b1;
        cyc(4);
        expect_out(16'h0001, 16'h0001);
        mem_oe <= 1'b0;
        cyc(4);
        expect_out(16'h0001, 16'h0000);
        // own drive reaches the pin and comes back through the receiver
        oe <= 1'b1;
        drv <= 1'b1;
        cyc(4);
        expect_out(16'h0005, 16'h0005);
        oe <= 1'b0;
        drv <= 1'b0;
        xfer <= 1'b1;
        cyc(4);
        for (int k = 0; k < 4; k++) begin
            cyc(8);
            expect_out(16'h0002, (k % 2 == 0) ? 16'h0002 : 16'h0000);
        end
        xfer <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            req <= 4'($random(seed));
            cyc(2);
            expect_out(16'hF000, {~req, 12'h000});
        end
        req <= 4'hF;
        for (int i = 0; i < 4; i++) begin
            fault <= 4'h1 << i;
            cyc(13);
            expect_out(16'hFF00, {4'h1 << i, 4'h1 << i, 8'h00});
            fault <= 4'h0;
            cyc(6);
        end
        end_sim();
    end
endmodule : hpp_top_tb
bind hpp_top hpp_top_checker i_hpp_top_checker (.REF_CLK_IN, .RSTN_IN, .PORT_OVERCURRENT_N_IN,
    .HUB_SUSPEND_IN, .MEM_DATA_OE_IN, .MEM_DATA_OR_POWER_MODE_OE_OUT, .MEM_SERIAL_CLK_OUT,
    .MEM_SERIAL_CLK_OE_OUT, .MEM_DATA_RX_OUT, .PORT_POWER_ENABLE_N_OUT, .PORT_OVERCURRENT_OUT,
    .SUSPEND_STATUS_OUT, .GANGED_MODE_OUT, .USE_DIRECT_CLOCK_OUT, .MULT_POWER_DOWN_OUT);
